// ==== common/bftx_pkg.sv ====
// bftx_pkg: constants and types of the bit, flag and transfer executor
// Contract
// - branch_no_overflow jumps k+1 if V clear
// - irq branches jump on I set or clear
// - io bit set/clear, 2 cycles, I/O 0..1F
// - bit set/clear rewrites whole register read back
// - bit skip tests on I/O 0..1F
// - rotates through carry, flags Z C N V
// - capture bit into T, deposit T back
// - single flag set/clear touches only it
// - indirect load 2 cycles, post-inc, pre-dec
// - offset load from Y or Z, pointer kept
// - indirect stores, all pointer forms except offset from X, 2 cycles
// - direct load and store, 2 cycles
// - program read via Z, 3 cycles, R0 default
// - extended program read uses page register above Z
// - push/pop 2 cycles, port write 1 cycle
// - in/out use I/O 0..3F, data adds 20
// - extended I/O only by data-space access
// - nop, sleep, watchdog kick one cycle
package bftx_pkg;
	// ----------------------------------------
	// address map
	// ----------------------------------------
	localparam logic [15:0] IO_DATA_OFFSET = 16'h0020;
	localparam logic [15:0] EXT_IO_FIRST = 16'h0060;
	localparam logic [5:0] BIT_IO_LAST = 6'h1F;
	localparam logic [5:0] IO_PAGE_EXT = 6'h3B;
	localparam logic [5:0] IO_JUMP_EXT = 6'h3C;
	localparam logic [5:0] IO_SP_LOW = 6'h3D;
	localparam logic [5:0] IO_SP_HIGH = 6'h3E;
	localparam logic [5:0] IO_FLAGS = 6'h3F;
	// ----------------------------------------
	// fields, indices, resets, cycle counts
	// ----------------------------------------
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	localparam int PAGE_W = 2;
	localparam logic [4:0] IDX_R0 = 5'h00;
	localparam logic [4:0] IDX_X = 5'h1A;
	localparam logic [4:0] IDX_Y = 5'h1C;
	localparam logic [4:0] IDX_Z = 5'h1E;
	localparam logic [4:0] IDX_HI = 5'h01;
	localparam logic [15:0] ONE16 = 16'h0001;
	localparam logic [15:0] TWO_WORD = 16'h0002;
	localparam logic [7:0] BIT_ONE = 8'h01;
	localparam logic [7:0] RSV_ZERO = 8'h00;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [15:0] SP_RST = 16'h0000;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [PAGE_W-1:0] PAGE_RST = 2'h0;
	localparam logic JUMP_RST = 1'h0;
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_SLEEP = 5'h01, OP_WDR = 5'h02, OP_BREAK = 5'h03,
		OP_BR_NOV = 5'h04, OP_BR_ION = 5'h05, OP_BR_IOFF = 5'h06,
		OP_IO_SET = 5'h07, OP_IO_CLR = 5'h08, OP_SKIP_ONE = 5'h09, OP_SKIP_ZERO = 5'h0A,
		OP_ROL = 5'h0B, OP_ROR = 5'h0C, OP_LSL = 5'h0D, OP_LSR = 5'h0E, OP_ASR = 5'h0F,
		OP_T_CAP = 5'h10, OP_T_DEP = 5'h11, OP_FLAG_ONE = 5'h12, OP_FLAG_ZERO = 5'h13,
		OP_READ_IND = 5'h14, OP_READ_DIR = 5'h15, OP_WRITE_IND = 5'h16,
		OP_WRITE_DIR = 5'h17, OP_PM_READ = 5'h18, OP_PM_EXT = 5'h19,
		OP_PUSH = 5'h1A, OP_POP = 5'h1B, OP_IN = 5'h1C, OP_OUT = 5'h1D
	} bftx_op_type;
	typedef enum logic [2:0] {
		AM_PLAIN = 3'h0, AM_POST_INC = 3'h1, AM_PRE_DEC = 3'h2,
		AM_DISP = 3'h3, AM_IMPLICIT = 3'h4
	} bftx_am_type;
	typedef enum logic [1:0] {PTR_X = 2'h0, PTR_Y = 2'h1, PTR_Z = 2'h2} bftx_ptr_type;
	typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_BUSY = 1'b1} bftx_state_type;
	typedef struct packed {
		bftx_op_type op;
		logic [4:0] rd;
		logic [2:0] bsel;
		logic [5:0] io;
		bftx_ptr_type ptr;
		bftx_am_type am;
		logic [5:0] disp;
		logic [15:0] k;
		logic [6:0] rel;
	} bftx_instr_type;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic re;
		logic we;
	} bftx_mem_req_type;
endpackage

// ==== src/bftx_exec.sv ====
// bftx_exec: executor for bit, flag, transfer, stack and control operations
`timescale 1ns/1ps
module bftx_exec (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic op_valid_i,
	input wire bftx_pkg::bftx_instr_type op_i,
	output logic op_ready_o,
	output bftx_pkg::bftx_mem_req_type mem_req_o,
	input wire logic [7:0] mem_rdata_i,
	output logic [17:0] pm_addr_o,
	input wire logic [7:0] pm_rdata_i,
	output logic [15:0] pc_o,
	output logic [7:0] flags_o,
	output logic skip_o,
	output logic sleep_o,
	output logic kick_o,
	output logic break_o,
	output logic illegal_o
);
	import bftx_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	bftx_state_type state;
	logic [1:0] cnt;
	bftx_instr_type cur;
	logic cur_hit;
	logic [7:0] gpr [32];
	logic [7:0] flags;
	logic [15:0] sp;
	logic [PAGE_W-1:0] page_ext;
	logic jump_ext;
	logic [15:0] pc;

	logic acc, fin, bad, is_rd, is_wr, is_bio, is_pm, is_ind, is_sh, taken, hit;
	logic sh_c, skip_hit, ptr_we, byte_we, fin_load;
	logic [1:0] cycles;
	logic [4:0] plo, byte_idx;
	logic [7:0] rd_val, sh_res, dep_res, load_data, rmw_data, core_val;
	logic [7:0] bmask, cmask, byte_data, next_flags;
	logic [15:0] ptr_val, ind_addr, io_addr, daddr, next_pc, ptr_new, next_sp;
	logic [17:0] pm_full, pm_inc;
	logic [PAGE_W-1:0] next_page;

	function automatic logic [15:0] to_data(input logic [5:0] io);
		return {10'h000, io} + IO_DATA_OFFSET;
	endfunction

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign op_ready_o = (state == ST_IDLE);
	assign acc = op_valid_i && op_ready_o;
	assign fin = (state == ST_BUSY) && (cnt == CYC_ONE);
	assign rd_val = gpr[op_i.rd];
	assign is_rd = op_i.op inside {OP_READ_IND, OP_READ_DIR, OP_POP, OP_IN};
	assign is_wr = op_i.op inside {OP_WRITE_IND, OP_WRITE_DIR, OP_PUSH, OP_OUT};
	assign is_bio = op_i.op inside {OP_IO_SET, OP_IO_CLR, OP_SKIP_ONE, OP_SKIP_ZERO};
	assign is_pm = op_i.op inside {OP_PM_READ, OP_PM_EXT};
	assign is_ind = op_i.op inside {OP_READ_IND, OP_WRITE_IND};
	assign is_sh = op_i.op inside {OP_ROL, OP_ROR, OP_LSL, OP_LSR, OP_ASR};

	assign bad = (is_bio && (op_i.io > BIT_IO_LAST))
		|| (is_ind && (op_i.am == AM_DISP) && (op_i.ptr == PTR_X));

	// ----------------------------------------
	// addressing
	// ----------------------------------------
	assign plo = is_pm ? IDX_Z : (op_i.ptr == PTR_Y) ? IDX_Y : (op_i.ptr == PTR_Z) ? IDX_Z : IDX_X;
	assign ptr_val = {gpr[plo | IDX_HI], gpr[plo]};

	assign ind_addr = (op_i.am == AM_PRE_DEC) ? ptr_val - ONE16
		: (op_i.am == AM_DISP) ? ptr_val + {10'h000, op_i.disp} : ptr_val;

	assign io_addr = to_data(op_i.io);

	always_comb begin
		case (op_i.op)
			OP_READ_IND, OP_WRITE_IND: daddr = ind_addr;
			OP_READ_DIR, OP_WRITE_DIR: daddr = op_i.k;
			OP_PUSH: daddr = sp;
			OP_POP: daddr = sp + ONE16;
			default: daddr = io_addr;
		endcase
	end

	assign hit = (daddr >= to_data(IO_PAGE_EXT)) && (daddr <= to_data(IO_FLAGS));

	// core registers seen in data space, reserved bits read zero
	always_comb begin
		core_val = RSV_ZERO;
		if (mem_req_o.addr == to_data(IO_FLAGS)) begin
			core_val = flags;
		end else if (mem_req_o.addr == to_data(IO_SP_HIGH)) begin
			core_val = sp[15:8];
		end else if (mem_req_o.addr == to_data(IO_SP_LOW)) begin
			core_val = sp[7:0];
		end else if (mem_req_o.addr == to_data(IO_PAGE_EXT)) begin
			core_val = {{(8 - PAGE_W){1'b0}}, page_ext};
		end else if (mem_req_o.addr == to_data(IO_JUMP_EXT)) begin
			core_val = {7'h00, jump_ext};
		end
	end

	assign load_data = cur_hit ? core_val : mem_rdata_i;
	assign bmask = BIT_ONE << cur.bsel;
	assign cmask = BIT_ONE << op_i.bsel;

	assign rmw_data = (cur.op == OP_IO_SET) ? (mem_rdata_i | bmask) : (mem_rdata_i & ~bmask);

	assign skip_hit = (|(mem_rdata_i & bmask)) == (cur.op == OP_SKIP_ONE);

	assign dep_res = flags[FLAG_T] ? (rd_val | cmask) : (rd_val & ~cmask);

	// ----------------------------------------
	// shifter
	// ----------------------------------------
	always_comb begin
		sh_res = rd_val;
		sh_c = flags[FLAG_C];
		case (op_i.op)
			OP_ROL: begin
				sh_res = {rd_val[6:0], flags[FLAG_C]};
				sh_c = rd_val[7];
			end
			OP_ROR: begin
				sh_res = {flags[FLAG_C], rd_val[7:1]};
				sh_c = rd_val[0];
			end
			OP_LSL: begin
				sh_res = {rd_val[6:0], 1'b0};
				sh_c = rd_val[7];
			end
			OP_LSR: begin
				sh_res = {1'b0, rd_val[7:1]};
				sh_c = rd_val[0];
			end
			OP_ASR: begin
				sh_res = {rd_val[7], rd_val[7:1]};
				sh_c = rd_val[0];
			end
			default: begin
				sh_res = rd_val;
				sh_c = flags[FLAG_C];
			end
		endcase
	end

	// ----------------------------------------
	// branch and cycle count
	// ----------------------------------------
	always_comb begin
		case (op_i.op)
			OP_BR_NOV: taken = !flags[FLAG_V];
			OP_BR_ION: taken = flags[FLAG_I];
			OP_BR_IOFF: taken = !flags[FLAG_I];
			default: taken = 1'b0;
		endcase
	end

	always_comb begin
		if (bad) begin
			cycles = CYC_ONE;
		end else if (taken) begin
			cycles = CYC_TWO;
		end else if (is_pm) begin
			cycles = CYC_THREE;
		end else if (is_rd || is_bio || (is_wr && op_i.op != OP_OUT)) begin
			cycles = CYC_TWO;
		end else begin
			cycles = CYC_ONE;
		end
	end

	always_comb begin
		if (taken && !bad) begin
			next_pc = pc + {{9{op_i.rel[6]}}, op_i.rel} + ONE16;
		end else if (!bad && op_i.op inside {OP_READ_DIR, OP_WRITE_DIR}) begin
			next_pc = pc + TWO_WORD;
		end else begin
			next_pc = pc + ONE16;
		end
	end

	// ----------------------------------------
	// pointer and program address
	// ----------------------------------------
	// page register above Z
	assign pm_full = {(op_i.op == OP_PM_EXT) ? page_ext : PAGE_RST, ptr_val};
	assign pm_inc = pm_full + {{PAGE_W{1'b0}}, ONE16};

	assign ptr_we = acc && !bad && ((is_ind && op_i.am inside {AM_POST_INC, AM_PRE_DEC})
		|| (is_pm && op_i.am == AM_POST_INC));
	assign ptr_new = is_pm ? pm_inc[15:0] : (op_i.am == AM_PRE_DEC) ? ind_addr : ptr_val + ONE16;

	// ----------------------------------------
	// next core register values
	// ----------------------------------------
	always_comb begin
		next_flags = flags;
		case (op_i.op)
			OP_ROL, OP_ROR, OP_LSL, OP_LSR, OP_ASR: begin
				next_flags[FLAG_C] = sh_c;
				next_flags[FLAG_Z] = (sh_res == RSV_ZERO);
				next_flags[FLAG_N] = sh_res[7];
				next_flags[FLAG_V] = sh_res[7] ^ sh_c;
			end
			OP_T_CAP: next_flags[FLAG_T] = rd_val[op_i.bsel];
			OP_FLAG_ONE: next_flags[op_i.bsel] = 1'b1;
			OP_FLAG_ZERO: next_flags[op_i.bsel] = 1'b0;
			default: next_flags = flags;
		endcase
		if (is_wr && daddr == to_data(IO_FLAGS)) begin
			next_flags = rd_val;
		end
	end

	always_comb begin
		next_sp = sp;
		if (is_wr && daddr == to_data(IO_SP_LOW)) begin
			next_sp[7:0] = rd_val;
		end
		if (is_wr && daddr == to_data(IO_SP_HIGH)) begin
			next_sp[15:8] = rd_val;
		end
		if (op_i.op == OP_PUSH) begin
			next_sp = sp - ONE16;
		end else if (op_i.op == OP_POP) begin
			next_sp = sp + ONE16;
		end
	end

	always_comb begin
		next_page = page_ext;
		if (is_wr && daddr == to_data(IO_PAGE_EXT)) begin
			next_page = rd_val[PAGE_W-1:0];
		end else if (op_i.op == OP_PM_EXT && op_i.am == AM_POST_INC) begin
			next_page = pm_inc[17:16];
		end
	end

	// ----------------------------------------
	// register file write ports
	// ----------------------------------------
	assign fin_load = fin && (cur.op inside {OP_READ_IND, OP_READ_DIR, OP_POP, OP_IN,
		OP_PM_READ, OP_PM_EXT});
	assign byte_we = fin_load || (acc && !bad && (is_sh || op_i.op == OP_T_DEP));

	assign byte_idx = !fin_load ? op_i.rd
		: (cur.op inside {OP_PM_READ, OP_PM_EXT} && cur.am == AM_IMPLICIT) ? IDX_R0 : cur.rd;
	assign byte_data = !fin_load ? ((op_i.op == OP_T_DEP) ? dep_res : sh_res)
		: (cur.op inside {OP_PM_READ, OP_PM_EXT}) ? pm_rdata_i : load_data;

	always_ff @(posedge clock_i) begin
		if (ptr_we) begin
			gpr[plo] <= ptr_new[7:0];
			gpr[plo | IDX_HI] <= ptr_new[15:8];
		end
		if (byte_we) begin
			gpr[byte_idx] <= byte_data;
		end
	end

	// ----------------------------------------
	// control
	// ----------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			cnt <= CYC_ONE;
			cur <= '0;
			cur_hit <= 1'b0;
		end else if (acc) begin
			state <= (cycles == CYC_ONE) ? ST_IDLE : ST_BUSY;
			cnt <= cycles - CYC_ONE;
			cur <= op_i;
			cur_hit <= hit;
		end else if (state == ST_BUSY) begin
			cnt <= cnt - CYC_ONE;
			state <= fin ? ST_IDLE : ST_BUSY;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pc <= PC_RST;
			skip_o <= 1'b0;
		end else begin
			skip_o <= fin && cur.op inside {OP_SKIP_ONE, OP_SKIP_ZERO} && skip_hit;
			if (acc) begin
				pc <= next_pc;
			end else if (fin && cur.op inside {OP_SKIP_ONE, OP_SKIP_ZERO} && skip_hit) begin
				pc <= pc + ONE16;
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sleep_o <= 1'b0;
			kick_o <= 1'b0;
			break_o <= 1'b0;
			illegal_o <= 1'b0;
		end else begin
			sleep_o <= acc && op_i.op == OP_SLEEP;
			kick_o <= acc && op_i.op == OP_WDR;
			break_o <= acc && op_i.op == OP_BREAK;
			illegal_o <= acc && bad;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			flags <= FLAGS_RST;
			sp <= SP_RST;
			page_ext <= PAGE_RST;
			jump_ext <= JUMP_RST;
		end else if (acc && !bad) begin
			flags <= next_flags;
			sp <= next_sp;
			page_ext <= next_page;
			if (is_wr && daddr == to_data(IO_JUMP_EXT)) begin
				jump_ext <= rd_val[0];
			end
		end
	end

	// ----------------------------------------
	// data and program memory requests
	// ----------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			mem_req_o <= '0;
			pm_addr_o <= '0;
		end else begin
			mem_req_o.re <= 1'b0;
			mem_req_o.we <= 1'b0;
			if (acc && !bad) begin
				mem_req_o.addr <= daddr;
				mem_req_o.wdata <= rd_val;
				mem_req_o.re <= (is_rd || is_bio) && !hit;
				mem_req_o.we <= is_wr && !hit;
				pm_addr_o <= pm_full;
			end else if (fin && cur.op inside {OP_IO_SET, OP_IO_CLR}) begin
				mem_req_o.wdata <= rmw_data;
				mem_req_o.we <= 1'b1;
			end
		end
	end

	assign pc_o = pc;
	assign flags_o = flags;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);

	property p_br_taken;
		acc && op_i.op == OP_BR_NOV && !flags[FLAG_V] |=> !op_ready_o ##1 op_ready_o;
	endproperty
	a_br_taken: assert property (p_br_taken) else $error("taken branch not two cycles");

	property p_irq_br;
		acc && op_i.op inside {OP_BR_ION, OP_BR_IOFF} && !taken
			|=> op_ready_o && pc_o == $past(pc_o) + ONE16;
	endproperty
	a_irq_br: assert property (p_irq_br) else $error("untaken branch wrong");

	property p_io_range;
		acc && op_i.op inside {OP_IO_SET, OP_IO_CLR} && op_i.io > BIT_IO_LAST
			|=> illegal_o && !mem_req_o.re && !mem_req_o.we;
	endproperty
	a_io_range: assert property (p_io_range) else $error("bit op out of range taken");

	property p_rmw;
		acc && op_i.op == OP_IO_SET && !bad |=> mem_req_o.re
			##1 mem_req_o.we && mem_req_o.wdata == ($past(mem_rdata_i) | bmask);
	endproperty
	a_rmw: assert property (p_rmw) else $error("set bit write back wrong");

	property p_skip;
		acc && op_i.op == OP_SKIP_ONE && !bad
			|=> ##1 skip_o == $past(mem_rdata_i[cur.bsel]);
	endproperty
	a_skip: assert property (p_skip) else $error("skip result wrong");

	property p_rol;
		acc && op_i.op == OP_ROL |=> op_ready_o && flags_o[FLAG_C] == $past(rd_val[7]);
	endproperty
	a_rol: assert property (p_rol) else $error("rotate carry wrong");

	property p_flag_one;
		acc && op_i.op == OP_FLAG_ONE |=> flags_o == ($past(flags_o) | $past(cmask));
	endproperty
	a_flag_one: assert property (p_flag_one) else $error("flag set touched others");

	property p_load;
		acc && op_i.op == OP_READ_IND && !bad |=> !op_ready_o ##1 op_ready_o;
	endproperty
	a_load: assert property (p_load) else $error("load not two cycles");

	property p_pm;
		acc && is_pm |=> !op_ready_o [*2] ##1 op_ready_o;
	endproperty
	a_pm: assert property (p_pm) else $error("program read not three cycles");

	property p_push;
		acc && op_i.op == OP_PUSH && !hit
			|=> sp == $past(sp) - ONE16 && mem_req_o.we && mem_req_o.addr == $past(sp);
	endproperty
	a_push: assert property (p_push) else $error("push pointer wrong");

	property p_in_map;
		acc && op_i.op inside {OP_IN, OP_OUT} |=> mem_req_o.addr == $past(io_addr);
	endproperty
	a_in_map: assert property (p_in_map) else $error("port offset wrong");

	property p_ext_io;
		acc && op_i.op inside {OP_IN, OP_OUT} |=> mem_req_o.addr < EXT_IO_FIRST;
	endproperty
	a_ext_io: assert property (p_ext_io) else $error("port reached extended space");

	c_taken: cover property (acc && op_i.op == OP_BR_ION && taken);
	c_rmw: cover property (acc && op_i.op == OP_IO_CLR && !bad ##2 mem_req_o.we);
	c_extended_program_read: cover property (acc && op_i.op == OP_PM_EXT && op_i.am == AM_POST_INC);
	c_pop: cover property (acc && op_i.op == OP_POP);
endmodule

// ==== verification/bftx_exec_tb.sv ====
// bftx_exec_tb: self-checking bench of the executor
`timescale 1ns/1ps
`define CHK(got, exp) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		err_total++; \
		$display("[FAIL] %0t got %0h exp %0h", $time, got, exp); \
	end \
end
module bftx_exec_tb;
	import bftx_pkg::*;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic op_valid_i = 1'b0;
	bftx_instr_type op_i = '0;
	logic op_ready_o, skip_o, sleep_o, kick_o, break_o, illegal_o;
	bftx_mem_req_type mem_req_o;
	logic [7:0] mem_rdata_i, pm_rdata_i, flags_o, wd;
	logic [17:0] pm_addr_o;
	logic [15:0] pc_o, wa, ra;
	logic [3:0] pul;
	int err_total = 0;
	int comparisons = 0;
	int wcnt = 0;
	int wc0;
	int scnt = 0;
	bftx_instr_type ins_x;
	bftx_op_type sh_op [5] = '{OP_ROL, OP_ROR, OP_LSL, OP_LSR, OP_ASR};
	logic [7:0] sh_res [5] = '{8'h02, 8'hC0, 8'h02, 8'h40, 8'hC0};
	logic [3:0] sh_fl [5] = '{4'h9, 4'h5, 4'h9, 4'h9, 4'h5};
	bftx_op_type mc_op [4] = '{OP_NOP, OP_SLEEP, OP_WDR, OP_BREAK};
	logic [3:0] mc_pul [4] = '{4'h0, 4'h1, 4'h2, 4'h4};
	always #2.5 clock_i = ~clock_i;
	bftx_exec u_dut (
		.clock_i(clock_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_i(op_i),
		.op_ready_o(op_ready_o), .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i),
		.pm_addr_o(pm_addr_o), .pm_rdata_i(pm_rdata_i), .pc_o(pc_o), .flags_o(flags_o),
		.skip_o(skip_o), .sleep_o(sleep_o), .kick_o(kick_o), .break_o(break_o),
		.illegal_o(illegal_o)
	);
	bftx_mem_model u_mem (
		.clock_i(clock_i), .mem_req_i(mem_req_o), .mem_rdata_o(mem_rdata_i),
		.pm_addr_i(pm_addr_o), .pm_rdata_o(pm_rdata_i)
	);
	// ----------------------------------------
	// data port monitor
	// ----------------------------------------
	always @(posedge clock_i) begin
		if (mem_req_o.we === 1'b1) begin
			wa <= mem_req_o.addr;
			wd <= mem_req_o.wdata;
			wcnt <= wcnt + 1;
		end
		if (mem_req_o.re === 1'b1) begin
			ra <= mem_req_o.addr;
		end
		if (skip_o === 1'b1) begin
			scnt <= scnt + 1;
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	function automatic bftx_instr_type mk(bftx_op_type op, logic [4:0] rd, logic [2:0] b,
		logic [5:0] io, bftx_am_type am, logic [5:0] dp, logic [15:0] k);
		mk = '{op: op, rd: rd, bsel: b, io: io, ptr: PTR_Z, am: am, disp: dp, k: k, rel: 7'h05};
	endfunction
	task automatic run(input bftx_instr_type ins, input int cyc, input logic [15:0] dpc);
		logic [15:0] pc0;
		int n;
		pc0 = pc_o;
		op_valid_i = 1'b1;
		op_i = ins;
		@(posedge clock_i);
		@(negedge clock_i);
		op_valid_i = 1'b0;
		pul = {illegal_o, break_o, kick_o, sleep_o};
		n = 1;
		while (op_ready_o !== 1'b1 && n < 10) begin
			@(negedge clock_i);
			n++;
		end
		@(negedge clock_i);
		`CHK(n, cyc);
		`CHK(pc_o, pc0 + dpc);
	endtask
	task automatic acc(input bftx_instr_type ins, input int cyc, input logic [15:0] dpc,
		input logic w, input logic [15:0] a, input logic [7:0] e);
		run(ins, cyc, dpc);
		if (w) begin
			`CHK(wa, a);
			`CHK(wd, e);
		end else begin
			`CHK(ra, a);
		end
	endtask
	task automatic ld(input logic [4:0] r, input logic [15:0] a);
		acc(mk(OP_READ_DIR, r, '0, '0, AM_PLAIN, '0, a), 2, 16'h0002, 1'b0, a, '0);
	endtask
	task automatic st(input logic [4:0] r, input logic [15:0] a, input logic [7:0] e);
		acc(mk(OP_WRITE_DIR, r, '0, '0, AM_PLAIN, '0, a), 2, 16'h0002, 1'b1, a, e);
	endtask
	task automatic flag(input bftx_op_type op, input int s);
		run(mk(op, '0, s[2:0], '0, AM_PLAIN, '0, '0), 1, 16'h0001);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		stop_test();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (8) @(negedge clock_i);
		`CHK(flags_o, FLAGS_RST);
		u_mem.mem[10'h1F0] = 8'h20;
		u_mem.mem[10'h1F1] = 8'h01;
		u_mem.mem[10'h1F2] = 8'hFF;
		u_mem.mem[10'h1F3] = 8'h01;
		u_mem.mem[10'h1F4] = 8'h81;
		u_mem.mem[10'h03C] = 8'h05;
		u_mem.mem[10'h025] = 8'hFF;
		rst_i = 1'b0;
		@(negedge clock_i);
		for (int s = 0; s < 8; s++) begin
			flag(OP_FLAG_ONE, s);
			`CHK(flags_o, 8'hFF >> (7 - s));
		end
		for (int s = 0; s < 8; s++) begin
			flag(OP_FLAG_ZERO, s);
			`CHK(flags_o, 8'hFE << s);
		end
		$display("test flags done");
		for (int v = 0; v < 2; v++) begin
			run(mk(OP_BR_NOV, '0, '0, '0, AM_PLAIN, '0, '0), v ? 1 : 2, v ? 16'h1 : 16'h6);
			run(mk(OP_BR_ION, '0, '0, '0, AM_PLAIN, '0, '0), v ? 2 : 1, v ? 16'h6 : 16'h1);
			run(mk(OP_BR_IOFF, '0, '0, '0, AM_PLAIN, '0, '0), v ? 1 : 2, v ? 16'h1 : 16'h6);
			flag(OP_FLAG_ONE, FLAG_V);
			flag(OP_FLAG_ONE, FLAG_I);
		end
		flag(OP_FLAG_ZERO, FLAG_V);
		flag(OP_FLAG_ZERO, FLAG_I);
		$display("test branches done");
		ld(IDX_Z, 16'h01F0);
		ld(IDX_Z + IDX_HI, 16'h01F1);
		acc(mk(OP_READ_IND, 5'h11, '0, '0, AM_POST_INC, '0, '0), 2, 1, 0, 16'h0120, '0);
		acc(mk(OP_WRITE_IND, 5'h11, '0, '0, AM_PLAIN, '0, '0), 2, 1, 1, 16'h0121, 8'h1C);
		acc(mk(OP_READ_IND, 5'h12, '0, '0, AM_PRE_DEC, '0, '0), 2, 1, 0, 16'h0120, '0);
		acc(mk(OP_WRITE_IND, 5'h12, '0, '0, AM_PRE_DEC, '0, '0), 2, 1, 1, 16'h011F, 8'h1C);
		acc(mk(OP_READ_IND, 5'h13, '0, '0, AM_DISP, 6'h05, '0), 2, 1, 0, 16'h0124, '0);
		acc(mk(OP_WRITE_IND, 5'h13, '0, '0, AM_PLAIN, '0, '0), 2, 1, 1, 16'h011F, 8'h18);
		acc(mk(OP_WRITE_IND, 5'h13, '0, '0, AM_DISP, 6'h02, '0), 2, 1, 1, 16'h0121, 8'h18);
		ins_x = mk(OP_READ_IND, 5'h15, '0, '0, AM_DISP, 6'h01, '0);
		ins_x.ptr = PTR_X;
		run(ins_x, 1, 1);
		`CHK(pul[3], 1'b1);
		ld(5'h14, 16'h01F4);
		st(5'h14, 16'h0180, 8'h81);
		$display("test transfers done");
		run(mk(OP_PM_READ, IDX_R0, '0, '0, AM_IMPLICIT, '0, '0), 3, 1);
		`CHK(pm_addr_o, 18'h0011F);
		st(IDX_R0, 16'h0181, 8'h1E);
		run(mk(OP_PM_READ, 5'h13, '0, '0, AM_POST_INC, '0, '0), 3, 1);
		`CHK(pm_addr_o, 18'h0011F);
		ld(5'h16, 16'h01F2);
		ld(5'h17, 16'h01F3);
		run(mk(OP_OUT, 5'h17, '0, IO_PAGE_EXT, AM_PLAIN, '0, '0), 1, 1);
		run(mk(OP_PM_EXT, 5'h13, '0, '0, AM_POST_INC, '0, '0), 3, 1);
		`CHK(pm_addr_o, 18'h10120);
		run(mk(OP_PM_EXT, IDX_R0, '0, '0, AM_IMPLICIT, '0, '0), 3, 1);
		`CHK(pm_addr_o, 18'h10121);
		st(IDX_R0, 16'h0182, 8'h21);
		$display("test program reads done");
		run(mk(OP_IO_SET, '0, 3'h1, 6'h1C, AM_PLAIN, '0, '0), 2, 1);
		`CHK(wa, 16'h003C);
		`CHK(wd, 8'h07);
		run(mk(OP_IO_CLR, '0, 3'h3, 6'h05, AM_PLAIN, '0, '0), 2, 1);
		`CHK(wd, 8'hF7);
		wc0 = wcnt;
		run(mk(OP_IO_SET, '0, 3'h1, 6'h20, AM_PLAIN, '0, '0), 1, 1);
		`CHK(pul[3], 1'b1);
		`CHK(wcnt, wc0);
		run(mk(OP_SKIP_ONE, '0, 3'h0, 6'h05, AM_PLAIN, '0, '0), 2, 2);
		run(mk(OP_SKIP_ONE, '0, 3'h3, 6'h05, AM_PLAIN, '0, '0), 2, 1);
		run(mk(OP_SKIP_ZERO, '0, 3'h3, 6'h05, AM_PLAIN, '0, '0), 2, 2);
		`CHK(scnt, 2);
		$display("test io bits done");
		for (int i = 0; i < 5; i++) begin
			flag((i == 1) ? OP_FLAG_ONE : OP_FLAG_ZERO, FLAG_C);
			ld(5'h14, 16'h01F4);
			run(mk(sh_op[i], 5'h14, '0, '0, AM_PLAIN, '0, '0), 1, 1);
			`CHK(flags_o, {4'h0, sh_fl[i]});
			st(5'h14, 16'h0183, sh_res[i]);
		end
		run(mk(OP_T_CAP, 5'h14, 3'h6, '0, AM_PLAIN, '0, '0), 1, 1);
		`CHK(flags_o, 8'h45);
		run(mk(OP_T_DEP, 5'h14, 3'h0, '0, AM_PLAIN, '0, '0), 1, 1);
		`CHK(flags_o, 8'h45);
		st(5'h14, 16'h0184, 8'hC1);
		$display("test shifts done");
		run(mk(OP_OUT, 5'h16, '0, IO_SP_LOW, AM_PLAIN, '0, '0), 1, 1);
		run(mk(OP_OUT, 5'h17, '0, IO_SP_HIGH, AM_PLAIN, '0, '0), 1, 1);
		run(mk(OP_IN, 5'h18, '0, IO_SP_LOW, AM_PLAIN, '0, '0), 2, 1);
		st(5'h18, 16'h0185, 8'hFF);
		run(mk(OP_OUT, 5'h17, '0, IO_JUMP_EXT, AM_PLAIN, '0, '0), 1, 1);
		run(mk(OP_IN, 5'h15, '0, IO_JUMP_EXT, AM_PLAIN, '0, '0), 2, 1);
		st(5'h15, 16'h0187, 8'h01);
		run(mk(OP_OUT, 5'h14, '0, 6'h05, AM_PLAIN, '0, '0), 1, 1);
		`CHK(wa, 16'h0025);
		acc(mk(OP_PUSH, 5'h14, '0, '0, AM_PLAIN, '0, '0), 2, 1, 1, 16'h01FF, 8'hC1);
		acc(mk(OP_PUSH, 5'h16, '0, '0, AM_PLAIN, '0, '0), 2, 1, 1, 16'h01FE, 8'hFF);
		acc(mk(OP_POP, 5'h19, '0, '0, AM_PLAIN, '0, '0), 2, 1, 0, 16'h01FE, '0);
		st(5'h19, 16'h0186, 8'hFF);
		$display("test stack done");
		for (int i = 0; i < 4; i++) begin
			run(mk(mc_op[i], '0, '0, '0, AM_PLAIN, '0, '0), 1, 1);
			`CHK(pul, mc_pul[i]);
		end
		rst_i = 1'b1;
		@(negedge clock_i);
		`CHK(pc_o, PC_RST);
		`CHK(flags_o, FLAGS_RST);
		rst_i = 1'b0;
		@(negedge clock_i);
		flag(OP_FLAG_ONE, FLAG_C);
		`CHK(flags_o, 8'h01);
		$display("test control done");
		stop_test();
	end
endmodule

// ==== verification/bftx_mem_model.sv ====
// bftx_mem_model: data space and program memory facing the executor
`timescale 1ns/1ps
module bftx_mem_model (
	input wire logic clock_i,
	input wire bftx_pkg::bftx_mem_req_type mem_req_i,
	output logic [7:0] mem_rdata_o,
	input wire logic [17:0] pm_addr_i,
	output logic [7:0] pm_rdata_o
);
	import bftx_pkg::*;
	localparam logic [15:0] W1C_ADDR = 16'h003C;
	logic [7:0] mem [0:1023];
	logic [7:0] junk;
	initial begin
		junk = 8'h5A;
		for (int i = 0; i < 1024; i++) begin
			mem[i] = i[7:0] ^ 8'h3C;
		end
	end
	// read in request cycle
	// no stale value while idle
	assign mem_rdata_o = mem_req_i.re ? mem[mem_req_i.addr[9:0]] : junk;
	always @(posedge clock_i) begin
		junk <= junk + 8'h35;
		pm_rdata_o <= pm_addr_i[7:0] ^ pm_addr_i[15:8] ^ {6'h00, pm_addr_i[17:16]};
		if (mem_req_i.we === 1'b1) begin
			if (mem_req_i.addr == W1C_ADDR) begin
				mem[mem_req_i.addr[9:0]] <= mem[mem_req_i.addr[9:0]] & ~mem_req_i.wdata;
			end else begin
				mem[mem_req_i.addr[9:0]] <= mem_req_i.wdata;
			end
		end
	end
endmodule
